// ---- include/cofa_pkg.sv ----
// shared constants, types and helpers for the operand format and align core
package cofa_pkg;

  //////////////////////////////////////////////////////////////////////////
  // operand sizes
  typedef logic [1:0] cofa_size_t;          // operand size code
  localparam cofa_size_t SZ_BYTE = 2'h0;    // 8-bit operand
  localparam cofa_size_t SZ_WORD = 2'h1;    // 16-bit operand
  localparam cofa_size_t SZ_LONG = 2'h2;    // 32-bit operand, code 3 aliases

  //////////////////////////////////////////////////////////////////////////
  // register offsets on the wishbone bus (byte addresses)
  localparam logic [7:0] OFF_CTRL   = 8'h00; // operation control, write runs
  localparam logic [7:0] OFF_FLAGS  = 8'h04; // condition_flags
  localparam logic [7:0] OFF_INDEX  = 8'h08; // register file index
  localparam logic [7:0] OFF_DATA   = 8'h0C; // long view of indexed register
  localparam logic [7:0] OFF_ADDR   = 8'h10; // raw access address
  localparam logic [7:0] OFF_AMODE  = 8'h14; // access size and fetch bit
  localparam logic [7:0] OFF_ALIGN  = 8'h18; // aligned access address
  localparam logic [7:0] OFF_STATUS = 8'h1C; // busy, illegal, adjusted
  localparam logic [7:0] OFF_MEMIMG = 8'h20; // indexed register in mem order

  //////////////////////////////////////////////////////////////////////////
  // condition_flags bit positions and reset value
  localparam int unsigned FLAG_C = 0;       // carry
  localparam int unsigned FLAG_Z = 2;       // zero
  localparam int unsigned FLAG_N = 3;       // negative
  localparam int unsigned FLAG_H = 5;       // half carry
  localparam logic [7:0]  FLAGS_RST = 8'h00;

  // status bit positions
  localparam int unsigned STS_BUSY    = 0;
  localparam int unsigned STS_ILLEGAL = 1;
  localparam int unsigned STS_ADJUST  = 2;

  //////////////////////////////////////////////////////////////////////////
  // carry, half carry and sign bit positions per operand size
  localparam int unsigned CY_B = 8;
  localparam int unsigned CY_W = 16;
  localparam int unsigned CY_L = 32;
  localparam int unsigned HC_B = 4;
  localparam int unsigned HC_W = 12;
  localparam int unsigned HC_L = 28;
  localparam int unsigned MS_B = 7;
  localparam int unsigned MS_W = 15;
  localparam int unsigned MS_L = 31;

  // packed decimal correction constants
  localparam logic [7:0] BCD_LO_ADJ = 8'h06;
  localparam logic [7:0] BCD_HI_ADJ = 8'h60;
  localparam logic [3:0] BCD_DIG_MAX = 4'h9;
  localparam logic [7:0] BCD_BYTE_MAX = 8'h99;

  //////////////////////////////////////////////////////////////////////////
  // instruction types
  localparam logic [5:0] INSN_TYPES = 6'h3E; // 62 distinct types
  localparam logic [5:0] OP_CNT     = 6'h16; // types with a datapath op

  typedef enum logic [4:0] {
    OP_ADD, OP_ADDX, OP_SUB, OP_SUBX, OP_CMP, OP_NEG,
    OP_SHLL, OP_SHLR, OP_ROTL, OP_ROTR,
    OP_DADD, OP_DSUB,
    OP_BSET, OP_BCLR, OP_BNOT, OP_BTST, OP_BLD, OP_BST,
    OP_BAND, OP_BOR, OP_BXOR,
    OP_MOV, OP_NOP
  } cofa_op_t;

  // control register layout, bit 19 down to bit 0
  typedef struct packed {
    logic       s_sel;   // source: high byte / extended half
    logic [2:0] s_idx;   // source register number
    logic       d_sel;   // destination: high byte / extended half
    logic [2:0] d_idx;   // destination register number
    logic       rsv;     // reads as zero
    logic [2:0] bitn;    // bit number within a byte operand
    cofa_size_t size;    // operand size
    logic [5:0] itype;   // instruction type code
  } cofa_ctrl_t;

  // one register view: number plus half select
  typedef struct packed {
    logic [2:0] idx;
    logic       sel;
  } cofa_view_t;

  // address mode: fetch flag plus access size
  typedef struct packed {
    logic       fetch;
    cofa_size_t size;
  } cofa_amode_t;

  // pick one bit of a 33-bit value at a size dependent position
  function automatic logic cofa_pick(input logic [32:0] v,
                                     input cofa_size_t sz,
                                     input int unsigned pb,
                                     input int unsigned pw,
                                     input int unsigned pl);
    cofa_pick = (sz == SZ_BYTE) ? v[pb] : (sz == SZ_WORD) ? v[pw] : v[pl];
  endfunction : cofa_pick

endpackage : cofa_pkg

// ---- logic/cofa_regfile.sv ----
// general register file with byte, word and long views
`timescale 1ns/1ps
module cofa_regfile
  import cofa_pkg::*;
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // read port a and b, zero extended views
  input  wire cofa_view_t  rd_a_view_i,
  input  wire cofa_view_t  rd_b_view_i,
  input  wire cofa_size_t  rd_size_i,
  output logic [31:0]      rd_a_o,
  output logic [31:0]      rd_b_o,
  // long read port for software
  input  wire logic [2:0]  rd_long_idx_i,
  output logic [31:0]      rd_long_o,
  // write port
  input  wire logic        wr_en_i,
  input  wire cofa_view_t  wr_view_i,
  input  wire cofa_size_t  wr_size_i,
  input  wire logic [31:0] wr_data_i
);

  logic [31:0] regs_r [8];  // eight long registers, views overlay them

  // byte views pick bits 15:8 or 7:0, word views 31:16 or 15:0
  function automatic logic [31:0] view_read(input logic [31:0] r,
                                            input cofa_size_t sz,
                                            input logic sel);
    if (sz == SZ_BYTE) begin
      view_read = {24'h000000, sel ? r[15:8] : r[7:0]};
    end else if (sz == SZ_WORD) begin
      view_read = {16'h0000, sel ? r[31:16] : r[15:0]};
    end else begin
      view_read = r;
    end
  endfunction : view_read

  // merge a narrow write into the long register, rest untouched
  function automatic logic [31:0] view_write(input logic [31:0] r,
                                             input logic [31:0] d,
                                             input cofa_size_t sz,
                                             input logic sel);
    if (sz == SZ_BYTE) begin
      view_write = sel ? {r[31:16], d[7:0], r[7:0]} : {r[31:8], d[7:0]};
    end else if (sz == SZ_WORD) begin
      view_write = sel ? {d[15:0], r[15:0]} : {r[31:16], d[15:0]};
    end else begin
      view_write = d;
    end
  endfunction : view_write

  //////////////////////////////////////////////////////////////////////////
  // views overlay the same storage
  assign rd_a_o    = view_read(regs_r[rd_a_view_i.idx], rd_size_i,
                               rd_a_view_i.sel); // RULE_13
  assign rd_b_o    = view_read(regs_r[rd_b_view_i.idx], rd_size_i,
                               rd_b_view_i.sel); // RULE_13
  assign rd_long_o = regs_r[rd_long_idx_i]; // RULE_14

  // storage update, cleared on reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < 8; i++) begin
        regs_r[i] <= 32'h00000000;
      end
    end else if (wr_en_i) begin
      regs_r[wr_view_i.idx] <= view_write(regs_r[wr_view_i.idx], wr_data_i,
                                          wr_size_i, wr_view_i.sel); // RULE_14
    end
  end

endmodule : cofa_regfile

// ---- logic/cofa_align.sv ----
// access address alignment and big-endian memory byte order
`timescale 1ns/1ps
module cofa_align
  import cofa_pkg::*;
(
  // requested access
  input  wire logic [31:0] addr_i,
  input  wire cofa_amode_t mode_i,
  input  wire logic [31:0] data_i,
  // aligned result
  output logic [31:0]      addr_o,
  output logic             adjusted_o,
  output logic [31:0]      mem_img_o
);

  wire force_even;  // word, long or fetch: bit 0 must be zero

  // no error on an odd address: the access slides one byte lower
  assign force_even = mode_i.fetch | (mode_i.size != SZ_BYTE); // RULE_09 RULE_10
  assign adjusted_o = force_even & addr_i[0];
  assign addr_o     = {addr_i[31:1], addr_i[0] & ~force_even}; // RULE_09

  // byte at the lowest address lands in bits 7:0, upper byte goes first
  assign mem_img_o =
    (mode_i.size == SZ_BYTE) ? {24'h000000, data_i[7:0]} :
    (mode_i.size == SZ_WORD) ? {16'h0000, data_i[7:0], data_i[15:8]} :
    {data_i[7:0], data_i[15:8], data_i[23:16], data_i[31:24]}; // RULE_15

endmodule : cofa_align

// ---- logic/cofa_core.sv ----
// operand format and align core: alu, flags, register views, wishbone
// Operation
// RULE_01 - carry set on carry, cleared otherwise
// RULE_02 - subtraction reports borrow in carry
// RULE_03 - shifts and rotates load shifted-out bit
// RULE_04 - bit operations accumulate in carry
// RULE_05 - bit, bcd, byte, word, long operands
// RULE_06 - bit ops touch one bit 0-7
// RULE_07 - decimal adjust treats byte as two digits
// RULE_08 - software places word/long at even address
// RULE_09 - odd word/long address forced even, no error
// RULE_10 - fetch addresses forced even too
// RULE_11 - stack accesses should use word or long
// RULE_12 - decoder knows exactly 62 instruction types
// RULE_13 - sixteen byte and sixteen word views
// RULE_14 - eight long registers overlay narrower views
// RULE_15 - memory data stored upper byte first
// RULE_16 - bcd upper digit bits 7:4, lower 3:0
//
// Implementation choices: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ps
module cofa_core
  import cofa_pkg::*;
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone classic slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [31:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // memory and fetch bus address
  output logic [31:0]      mem_addr_o,
  output cofa_amode_t      mem_mode_o,
  // carry flag for neighbouring logic
  output logic             carry_o
);

  //////////////////////////////////////////////////////////////////////////
  // state
  logic             ack_r;       // one-cycle acknowledge
  logic [31:0]      dat_r;       // read data captured for the master
  cofa_ctrl_t       ctrl_r;      // last operation control
  logic             exec_r;      // operation runs on this edge
  logic [7:0]       flags_r;     // condition_flags
  logic [7:0]       flags_nxt;
  logic [2:0]       index_r;     // register chosen for software access
  logic [31:0]      addr_r;      // raw access address
  cofa_amode_t      amode_r;     // access size and fetch flag
  logic [31:0]      algn_r;      // aligned address towards memory
  logic             adj_r;       // last alignment moved the address
  logic             illegal_r;   // sticky: unknown type executed

  //////////////////////////////////////////////////////////////////////////
  // bus decode
  wire        req       = wb_cyc_i & wb_stb_i;
  wire        commit    = req & ack_r;  // edge where master sees ack
  wire        wr_commit = commit & wb_we_i;
  wire [7:0]  off       = wb_adr_i[7:0];
  wire        hit_ctrl  = (off == OFF_CTRL);
  wire        hit_flags = (off == OFF_FLAGS);
  wire        hit_index = (off == OFF_INDEX);
  wire        hit_data  = (off == OFF_DATA);
  wire        hit_addr  = (off == OFF_ADDR);
  wire        hit_amode = (off == OFF_AMODE);
  wire        hit_align = (off == OFF_ALIGN);
  wire        hit_sts   = (off == OFF_STATUS);
  wire        hit_img   = (off == OFF_MEMIMG);

  // byte lanes: only enabled lanes take new data
  function automatic logic [31:0] lane_merge(input logic [31:0] old,
                                             input logic [31:0] nw,
                                             input logic [3:0] sel);
    for (int i = 0; i < 4; i++) begin
      lane_merge[i*8 +: 8] = sel[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction : lane_merge

  //////////////////////////////////////////////////////////////////////////
  // decode of the instruction type
  wire        illegal  = (ctrl_r.itype >= INSN_TYPES); // RULE_12
  // types past the datapath ops and below 62 are legal but leave the datapath idle
  wire cofa_op_t op    = (ctrl_r.itype < OP_CNT) ?
                         cofa_op_t'(ctrl_r.itype[4:0]) : OP_NOP; // RULE_12
  wire        is_bit   = (op inside {OP_BSET, OP_BCLR, OP_BNOT, OP_BTST,
                                     OP_BLD, OP_BST, OP_BAND, OP_BOR,
                                     OP_BXOR});
  wire        is_dec   = (op inside {OP_DADD, OP_DSUB});
  // bit and decimal operations always work on a byte view
  wire cofa_size_t esz = (is_bit | is_dec) ? SZ_BYTE : ctrl_r.size; // RULE_05

  //////////////////////////////////////////////////////////////////////////
  // register file and alignment units
  logic [31:0] rf_a;       // destination operand view
  logic [31:0] rf_b;       // source operand view
  logic [31:0] rf_long;    // indexed long register
  logic [31:0] alu_res;
  logic        alu_we;
  logic        rf_we;
  cofa_view_t  rf_wview;
  cofa_size_t  rf_wsize;
  logic [31:0] rf_wdata;
  logic [31:0] algn_addr;
  logic        algn_adj;
  logic [31:0] mem_img;

  cofa_regfile u_regs (
    .clk_i         (clk_i),
    .rst_i         (rst_i),
    .rd_a_view_i   ({ctrl_r.d_idx, ctrl_r.d_sel}),
    .rd_b_view_i   ({ctrl_r.s_idx, ctrl_r.s_sel}),
    .rd_size_i     (esz),
    .rd_a_o        (rf_a),
    .rd_b_o        (rf_b),
    .rd_long_idx_i (index_r),
    .rd_long_o     (rf_long),
    .wr_en_i       (rf_we),
    .wr_view_i     (rf_wview),
    .wr_size_i     (rf_wsize),
    .wr_data_i     (rf_wdata)
  );

  cofa_align u_align (
    .addr_i     (addr_r),
    .mode_i     (amode_r),
    .data_i     (rf_long),
    .addr_o     (algn_addr),
    .adjusted_o (algn_adj),
    .mem_img_o  (mem_img)
  );

  //////////////////////////////////////////////////////////////////////////
  // arithmetic terms, 33 bits so carry or borrow sits at bit 8, 16 or 32 by size
  wire        cin     = flags_r[FLAG_C];
  wire [31:0] smask   = (esz == SZ_BYTE) ? 32'h000000FF :
                        (esz == SZ_WORD) ? 32'h0000FFFF : 32'hFFFFFFFF;
  wire [32:0] add_v   = {1'b0, rf_a} + {1'b0, rf_b} +
                        {32'h00000000, (op == OP_ADDX) & cin};
  wire [32:0] sub_v   = {1'b0, rf_a} - {1'b0, rf_b} -
                        {32'h00000000, (op == OP_SUBX) & cin};
  wire [32:0] neg_v   = 33'h000000000 - {1'b0, rf_a};
  wire        add_cy  = cofa_pick(add_v, esz, CY_B, CY_W, CY_L); // RULE_01
  wire        sub_bw  = cofa_pick(sub_v, esz, CY_B, CY_W, CY_L); // RULE_02
  wire        neg_bw  = cofa_pick(neg_v, esz, CY_B, CY_W, CY_L); // RULE_02
  wire [32:0] add_hx  = add_v ^ {1'b0, rf_a ^ rf_b};
  wire [32:0] sub_hx  = sub_v ^ {1'b0, rf_a ^ rf_b};
  wire        add_hc  = cofa_pick(add_hx, esz, HC_B, HC_W, HC_L);
  wire        sub_hc  = cofa_pick(sub_hx, esz, HC_B, HC_W, HC_L);
  wire        a_msb   = cofa_pick({1'b0, rf_a}, esz, MS_B, MS_W, MS_L);
  // the bit shifted in at the top by a right rotate
  wire [31:0] top_bit = (esz == SZ_BYTE) ? {24'h000000, rf_a[0], 7'h00} :
                        (esz == SZ_WORD) ? {16'h0000, rf_a[0], 15'h0000} :
                        {rf_a[0], 31'h00000000};

  // decimal digits: upper in bits 7:4, lower in bits 3:0
  wire        hcin    = flags_r[FLAG_H];
  wire        dfix_lo = hcin | (rf_a[3:0] > BCD_DIG_MAX); // RULE_16
  wire        dfix_hi = cin | (rf_a[7:0] > BCD_BYTE_MAX); // RULE_16
  wire [7:0]  dadd_v  = rf_a[7:0] + (dfix_lo ? BCD_LO_ADJ : 8'h00) +
                        (dfix_hi ? BCD_HI_ADJ : 8'h00); // RULE_07
  wire [7:0]  dsub_v  = rf_a[7:0] - (hcin ? BCD_LO_ADJ : 8'h00) -
                        (cin ? BCD_HI_ADJ : 8'h00); // RULE_07

  // single bit of the byte operand
  wire [7:0]  bmask   = 8'h01 << ctrl_r.bitn; // RULE_06
  wire        bval    = rf_a[ctrl_r.bitn];

  //////////////////////////////////////////////////////////////////////////
  // datapath: result, write enable and flag updates per operation
  always_comb begin
    alu_res   = rf_a;
    alu_we    = 1'b1;
    flags_nxt = flags_r;
    unique case (op)
      OP_ADD, OP_ADDX: begin
        alu_res           = add_v[31:0];
        flags_nxt[FLAG_C] = add_cy; // RULE_01
        flags_nxt[FLAG_H] = add_hc;
      end
      OP_SUB, OP_SUBX, OP_CMP: begin
        alu_res           = sub_v[31:0];
        alu_we            = (op != OP_CMP);
        flags_nxt[FLAG_C] = sub_bw; // RULE_02
        flags_nxt[FLAG_H] = sub_hc;
      end
      OP_NEG: begin
        alu_res           = neg_v[31:0];
        flags_nxt[FLAG_C] = neg_bw; // RULE_02
      end
      OP_SHLL: begin
        alu_res           = rf_a << 1;
        flags_nxt[FLAG_C] = a_msb; // RULE_03
      end
      OP_SHLR: begin
        alu_res           = rf_a >> 1;
        flags_nxt[FLAG_C] = rf_a[0]; // RULE_03
      end
      OP_ROTL: begin
        alu_res           = (rf_a << 1) | {31'h00000000, a_msb};
        flags_nxt[FLAG_C] = a_msb; // RULE_03
      end
      OP_ROTR: begin
        alu_res           = (rf_a >> 1) | top_bit;
        flags_nxt[FLAG_C] = rf_a[0]; // RULE_03
      end
      OP_DADD: begin
        alu_res           = {24'h000000, dadd_v}; // RULE_07
        flags_nxt[FLAG_C] = dfix_hi;
      end
      OP_DSUB: begin
        alu_res           = {24'h000000, dsub_v}; // RULE_07
      end
      // bit writes leave the other seven bits of the byte alone
      OP_BSET: alu_res = rf_a | {24'h000000, bmask}; // RULE_06
      OP_BCLR: alu_res = rf_a & ~{24'h000000, bmask}; // RULE_06
      OP_BNOT: alu_res = rf_a ^ {24'h000000, bmask}; // RULE_06
      OP_BTST: begin
        alu_we            = 1'b0;
        flags_nxt[FLAG_Z] = ~bval;
      end
      OP_BLD: begin
        alu_we            = 1'b0;
        flags_nxt[FLAG_C] = bval; // RULE_04
      end
      OP_BST: begin
        alu_res = cin ? (rf_a | {24'h000000, bmask}) :
                        (rf_a & ~{24'h000000, bmask}); // RULE_04
      end
      OP_BAND: begin
        alu_we            = 1'b0;
        flags_nxt[FLAG_C] = cin & bval; // RULE_04
      end
      OP_BOR: begin
        alu_we            = 1'b0;
        flags_nxt[FLAG_C] = cin | bval; // RULE_04
      end
      OP_BXOR: begin
        alu_we            = 1'b0;
        flags_nxt[FLAG_C] = cin ^ bval; // RULE_04
      end
      OP_MOV: alu_res = rf_b;
      OP_NOP: alu_we  = 1'b0;
    endcase
    // sign and zero follow the sized result of arithmetic and shifts
    if (!is_bit && (op != OP_MOV) && (op != OP_NOP)) begin
      flags_nxt[FLAG_Z] = ((alu_res & smask) == 32'h00000000);
      flags_nxt[FLAG_N] = cofa_pick({1'b0, alu_res}, esz, MS_B, MS_W, MS_L);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // register file write: operation first, software long write otherwise
  wire exec_we  = exec_r & ~illegal & alu_we;
  wire bus_we   = wr_commit & hit_data;
  assign rf_we    = exec_we | bus_we;
  assign rf_wview = exec_we ? cofa_view_t'({ctrl_r.d_idx, ctrl_r.d_sel}) :
                              cofa_view_t'({index_r, 1'b0});
  assign rf_wsize = exec_we ? esz : SZ_LONG; // RULE_14
  assign rf_wdata = exec_we ? (alu_res & smask) :
                              lane_merge(rf_long, wb_dat_i, wb_sel_i);

  //////////////////////////////////////////////////////////////////////////
  // read mux, unmapped offsets read zero
  wire [31:0] rd_mux =
    hit_ctrl  ? {12'h000, ctrl_r} :
    hit_flags ? {24'h000000, flags_r} :
    hit_index ? {29'h00000000, index_r} :
    hit_data  ? rf_long :
    hit_addr  ? addr_r :
    hit_amode ? {29'h00000000, amode_r} :
    hit_align ? algn_r :
    hit_sts   ? {29'h00000000, adj_r, illegal_r, exec_r} :
    hit_img   ? mem_img : 32'h00000000;

  wire [31:0] ctrl_w  = lane_merge({12'h000, ctrl_r}, wb_dat_i, wb_sel_i);
  wire [31:0] flags_w = lane_merge({24'h000000, flags_r}, wb_dat_i,
                                   wb_sel_i);
  wire [31:0] amode_w = lane_merge({29'h00000000, amode_r}, wb_dat_i,
                                   wb_sel_i);
  wire        ill_clr = wr_commit & hit_sts & wb_sel_i[0] &
                        wb_dat_i[STS_ILLEGAL];

  // acknowledge one cycle after the request, read data captured with it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      dat_r <= 32'h00000000;
    end else begin
      ack_r <= req & ~ack_r;
      if (req & ~ack_r) begin
        dat_r <= rd_mux;
      end
    end
  end

  // control register, a write starts the operation one edge later
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r <= '0;
      exec_r <= 1'b0;
    end else begin
      exec_r <= wr_commit & hit_ctrl;
      if (wr_commit & hit_ctrl) begin
        ctrl_r     <= cofa_ctrl_t'(ctrl_w[19:0]);
        ctrl_r.rsv <= 1'b0;
      end
    end
  end

  // flags: the running operation wins over a software write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flags_r <= FLAGS_RST;
    end else if (exec_r & ~illegal) begin
      flags_r <= flags_nxt; // RULE_01
    end else if (wr_commit & hit_flags) begin
      flags_r <= flags_w[7:0];
    end
  end

  // software access registers and the aligned address
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      index_r <= 3'h0;
      addr_r  <= 32'h00000000;
      amode_r <= '0;
      algn_r  <= 32'h00000000;
      adj_r   <= 1'b0;
    end else begin
      if (wr_commit & hit_index & wb_sel_i[0]) begin
        index_r <= wb_dat_i[2:0];
      end
      if (wr_commit & hit_addr) begin
        addr_r <= lane_merge(addr_r, wb_dat_i, wb_sel_i);
      end
      if (wr_commit & hit_amode) begin
        amode_r <= cofa_amode_t'(amode_w[2:0]);
      end
      algn_r <= algn_addr; // RULE_09 RULE_10
      adj_r  <= algn_adj;
    end
  end

  // sticky illegal type, a new event beats a same-cycle clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      illegal_r <= 1'b0;
    end else if (exec_r & illegal) begin
      illegal_r <= 1'b1; // RULE_12
    end else if (ill_clr) begin
      illegal_r <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // outputs
  assign wb_ack_o   = ack_r;
  assign wb_dat_o   = dat_r;
  assign mem_addr_o = algn_r;
  assign mem_mode_o = amode_r;
  assign carry_o    = flags_r[FLAG_C];

endmodule : cofa_core

// ---- bench/cofa_core_monitor.sv ----
// bus, carry and alignment checker for the operand format and align core
`timescale 1ns/1ps
module cofa_core_monitor
  import cofa_pkg::*;
(
  input wire logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o,
  input wire logic [31:0] wb_dat_o, mem_addr_o,
  input wire cofa_amode_t mem_mode_o,
  input wire logic        carry_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire req    = wb_cyc_i & wb_stb_i & ~wb_ack_o; // request still open
  wire wr_ack = wb_ack_o & wb_we_i;               // write lands here
  wire wide   = mem_mode_o.size != SZ_BYTE;       // word or long access
  wire fet    = mem_mode_o.fetch;                 // instruction fetch
  ack_latency_a: assert property (req |=> wb_ack_o) else $error("ack late");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack long");
  ack_cause_a: assert property (wb_ack_o |-> $past(req))
    else $error("ack without request");
  dat_hold_a: assert property ($changed(wb_dat_o) |-> wb_ack_o)
    else $error("read data moved");
  word_even_a: assert property ($past(wide) && $stable(mem_mode_o)
    |-> !mem_addr_o[0]) else $error("odd word address");
  fetch_even_a: assert property ($past(fet) && $stable(mem_mode_o)
    |-> !mem_addr_o[0]) else $error("odd fetch address");
  carry_cause_a: assert property ($changed(carry_o)
    |-> $past(wr_ack) || $past(wr_ack, 2)) else $error("carry moved alone");
  addr_cause_a: assert property ($changed(mem_addr_o)
    |-> $past(wr_ack) || $past(wr_ack, 2)) else $error("address moved");
  reset_val_a: assert property ($fell(rst_i) |-> mem_addr_o == 32'h0 &&
    !carry_o && mem_mode_o == 3'h0) else $error("bad reset value");
  cover property (wr_ack);
  cover property ($past(fet) && $stable(mem_mode_o));
  cover property ($rose(carry_o));
endmodule : cofa_core_monitor

// ---- bench/cofa_mem_model.sv ----
// memory model: each byte holds its own address, items placed even
`timescale 1ns/1ps
module cofa_mem_model
  import cofa_pkg::*;
(
  input  wire logic [31:0] mem_addr_i,
  input  wire cofa_amode_t mem_mode_i,
  output logic [31:0]      rd_o
);
  wire [7:0] b0 = mem_addr_i[7:0];
  // upper byte at the lowest address
  assign rd_o = (mem_mode_i.size == SZ_BYTE) ? {24'h0, b0} :
    {b0, b0 + 8'h1, b0 + 8'h2, b0 + 8'h3};
endmodule : cofa_mem_model

// ---- bench/cofa_core_tb.sv ----
// self-checking bench for the operand format and align core
`timescale 1ns/1ps
`define CHK(x, y) begin checked++; if ((x) !== (y)) begin mismatches++; \
  $display("mismatch %0t %h %h", $time, x, y); end end
module cofa_core_tb;
  import cofa_pkg::*;
  logic        clk_i = 0, rst_i = 1, cyc = 0, we = 0, ack, cy;
  logic [31:0] adr = 0, wdat = 0, rd, dat_o, maddr, pd, e;
  cofa_amode_t mmode;
  integer      mismatches = 0, checked = 0, seed = 44, i, k, a, b, c, h, r, n;
  int          ops[11] = '{0, 10, 2, 6, 7, 12, 16, 9, 14, 20, 3};
  cofa_core dut (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .mem_addr_o(maddr), .mem_mode_o(mmode), .carry_o(cy));
  cofa_mem_model mem (.mem_addr_i(maddr), .mem_mode_i(mmode), .rd_o(pd));
  initial forever #50 clk_i = ~clk_i;
  task stop_test;
    $display("mismatches %0d checked %0d", mismatches, checked);
    if (mismatches == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : stop_test
  // one classic cycle, held until ack is sampled high
  task wb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    integer t;
    cyc <= 1; we <= w; adr <= {24'h0, ad}; wdat <= d;
    t = 0;
    do begin @(posedge clk_i); t++; end while (ack !== 1'b1 && t < 50);
    if (t >= 50) begin mismatches++; stop_test(); end
    rd = dat_o;
    cyc <= 0;
    @(posedge clk_i);
  endtask : wb
  // byte model of dst = reg0 low byte, src = reg1 low byte
  task run(input integer op);
    integer x, y;
    x = a & 255; y = b & 255; r = x;
    case (op)
      0: begin r = x + y; c = r > 255; h = (x & 15) + (y & 15) > 15; end
      2: begin r = x - y; c = x < y; h = (x & 15) < (y & 15); end
      6: begin r = x << 1; c = x >> 7; end
      7: begin r = x >> 1; c = x & 1; end
      10: begin if (h || (x & 15) > 9) r += 6;
        c = c || x > 153; if (c) r += 96; end
      12: r = x | (1 << n);
      16: c = (x >> n) & 1;
      9: begin r = (x >> 1) | (x & 1) << 7; c = x & 1; end
      14: r = x ^ (1 << n);
      20: c = c ^ ((x >> n) & 1);
      3: begin r = x - y - c; c = x < y + c; end
    endcase
    a = (a & ~255) | (r & 255);
  endtask : run
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 0;
    for (i = 0; i < 4; i++) begin
      a = $random(seed); b = $random(seed);
      wb(1, OFF_INDEX, 1); wb(1, OFF_DATA, b); wb(1, OFF_INDEX, 0);
      wb(1, OFF_DATA, a);
      foreach (ops[k]) begin
        n = $random(seed) & 7;
        run(ops[k]);
        wb(1, OFF_CTRL, {12'h0, 8'h10, 1'b0, 3'(n), SZ_BYTE, 6'(ops[k])});
        wb(0, OFF_DATA, 0);
        `CHK(rd, 32'(a))
        wb(0, OFF_FLAGS, 0);
        `CHK({rd[0], cy}, {2{1'(c)}})
      end
    end
    wb(1, OFF_CTRL, 32'h3E); wb(0, OFF_STATUS, 0); `CHK(rd[1], 1'b1)
    wb(0, OFF_DATA, 0); `CHK(rd, 32'(a))
    wb(0, 8'h24, 0); `CHK(rd, 32'h0)
    for (k = 0; k < 6; k++) begin
      r = $random(seed) | 1;
      wb(1, OFF_ADDR, r); wb(1, OFF_AMODE, (k / 3) * 4 + k % 3);
      @(posedge clk_i);
      e = (k % 3 != 0 || k > 2) ? (r & ~1) : r;
      `CHK(maddr, e)
      `CHK(mmode, 3'((k / 3) * 4 + k % 3))
      `CHK((k % 3) ? pd[31:24] : pd[7:0], e[7:0])
      wb(0, OFF_ALIGN, 0); `CHK(rd, e)
      e = 32'(a);
      e = (k % 3 == 0) ? e & 255 : (k % 3 == 1) ? {e[7:0], e[15:8]} :
        {e[7:0], e[15:8], e[23:16], e[31:24]};
      wb(0, OFF_MEMIMG, 0); `CHK(rd, e)
    end
    stop_test();
  end
endmodule : cofa_core_tb
bind cofa_core cofa_core_monitor mon (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_ack_o, .wb_dat_o, .mem_addr_o, .mem_mode_o, .carry_o);
